// ===== stt_pkg.sv
// Purpose: Shared constants for the system tick timer.
// Assumes: APB data path of 32 bits, byte addresses as printed.
// Notes: Offsets are full byte addresses on the core's memory bus.
package stt_pkg;
  localparam int unsigned stt_addr_w = 32;
  localparam int unsigned stt_data_w = 32;
  localparam int unsigned stt_strb_w = 4;

  // Full variant map.
  localparam logic [31:0] stt_full_ctrl_addr = 32'he000f000;
  localparam logic [31:0] stt_full_stat_addr = 32'he000f004;
  localparam logic [31:0] stt_full_count_low_field_addr = 32'he000f008;
  localparam logic [31:0] stt_full_compare_low_field_addr = 32'he000f010;

  // Reduced variant map.
  localparam logic [31:0] stt_red_ctrl_addr = 32'he000f000;
  localparam logic [31:0] stt_red_count_low_field_addr = 32'he000f004;
  localparam logic [31:0] stt_red_count_high_field_addr = 32'he000f008;
  localparam logic [31:0] stt_red_compare_low_field_addr = 32'he000f00c;
  localparam logic [31:0] stt_red_compare_high_field_addr = 32'he000f010;

  // Event status and mask for the interrupt line, both variants.
  localparam logic [31:0] stt_evt_stat_addr = 32'he000f020;
  localparam logic [31:0] stt_evt_mask_addr = 32'he000f024;

  // Control field positions.
  localparam int unsigned stt_ctrl_count_enable = 0;
  localparam int unsigned stt_ctrl_irq_enable = 1;
  localparam int unsigned stt_ctrl_time_base = 2;
  localparam int unsigned stt_ctrl_reload = 3;
  localparam int unsigned stt_ctrl_down = 4;
  localparam int unsigned stt_ctrl_bits = 5;

  // Status field positions.
  localparam int unsigned stt_stat_compare_flag = 0;
  localparam int unsigned stt_stat_soft_trigger = 31;

  // Event bit positions.
  localparam int unsigned stt_evt_compare = 0;
  localparam int unsigned stt_evt_soft = 1;
  localparam int unsigned stt_evt_bits = 2;

  // Reset values.
  localparam logic [31:0] stt_ctrl_reset = 32'h00000000;
  localparam logic [31:0] stt_stat_reset = 32'h00000000;
  localparam logic [63:0] stt_count_reset = 64'h0000000000000000;

  // Slow time base: system clock divided by this figure.
  localparam int unsigned stt_slow_div = 8;
endpackage

// ===== stt_prescaler.sv
// Purpose: Produces a one-cycle enable pulse every DIV system clocks.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes: Free running so the slow time base keeps its phase.
`timescale 1ns/100ps
`default_nettype none
module stt_prescaler
#(
  parameter int unsigned DIV = stt_pkg::stt_slow_div
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Enable pulse.
  output logic tick_pulse
);
  import stt_pkg::*;

  localparam int unsigned cw = (DIV > 1) ? $clog2(DIV) : 1;

  logic [cw-1:0] div_reg;

  // A divider below two cannot make a pulse narrower than the clock.
  if (DIV < 2)
  begin : g_div_check
    $error("stt_prescaler: DIV must be at least 2");
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_reg <= '0;
      tick_pulse <= 1'b0;
    end
    else
    begin
      if (div_reg == cw'(DIV - 1))
        div_reg <= '0;
      else
        div_reg <= div_reg + cw'(1);
      tick_pulse <= (div_reg == cw'(DIV - 1));
    end
  end
endmodule // stt_prescaler
`default_nettype wire

// ===== stt_tick_timer.sv
// Purpose: System tick timer with APB register access and interrupts.
// Assumes: One clock pclk at 100 MHz; the clock is never gated in sleep.
// Notes: REDUCED selects the 64-bit variant with single-byte writes to count and compare.
// Summary of operation
// RULE1 - Counter is 32 bits, or 64 reduced.
// RULE2 - Control bit 2 picks clock or clock/8.
// RULE3 - Bit 4 sets direction; reload bit restarts.
// RULE4 - Without reload, counting continues past targets.
// RULE5 - Control bit 1 gates the tick interrupt.
// RULE6 - Control bit 0 runs or holds counter.
// RULE7 - Flag sets on target; write 0 clears.
// RULE8 - Count equal to compare raises tick interrupt.
// RULE9 - Status bit 31 holds software interrupt.
// RULE10 - Reduced compares full 64-bit values.
// RULE11 - Reduced count/compare accept byte writes only.
// RULE12 - Reduced: divide by eight, no extras.
// RULE13 - Full variant register map.
// RULE14 - Reduced variant register map.
// RULE15 - Counter keeps running during light sleep.
// RULE16 - Tick interrupt level follows flag and enable.
// RULE17 - Control and status reset to zero.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module stt_tick_timer
#(
  parameter bit REDUCED = 1'b0
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [stt_pkg::stt_addr_w-1:0] paddr,
  input wire logic [stt_pkg::stt_data_w-1:0] pwdata,
  input wire logic [stt_pkg::stt_strb_w-1:0] pstrb,
  output logic [stt_pkg::stt_data_w-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupts.
  output logic tick_irq,
  output logic soft_irq,
  output logic irq
);
  import stt_pkg::*;

  localparam int unsigned cnt_w = REDUCED ? 64 : 32;

  typedef enum logic [3:0] {
    stt_sel_none_type = 4'h0
  } stt_dummy_type;

  // Merges write data into a word by byte lane.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction

  // True when exactly one byte lane is enabled.
  function automatic logic one_lane(input logic [3:0] strb);
    return (strb == 4'h1) || (strb == 4'h2) || (strb == 4'h4) || (strb == 4'h8);
  endfunction

  logic [stt_ctrl_bits-1:0] ctrl_reg;
  logic compare_flag_reg;
  logic soft_trigger_reg;
  logic [63:0] count_reg;
  logic [63:0] compare_reg;
  logic [stt_evt_bits-1:0] evt_stat_reg;
  logic [stt_evt_bits-1:0] evt_mask_reg;
  logic slow_pulse;

  // Address decode.
  logic sel_ctrl;
  logic sel_stat;
  logic sel_count_low_field;
  logic sel_count_high_field;
  logic sel_compare_low_field;
  logic sel_compare_high_field;
  logic sel_evt;
  logic sel_mask;
  logic addr_hit;
  logic bad_write;
  logic setup_done;
  logic wr_fire;
  logic wr_ok;

  always_comb
  begin
    sel_ctrl = 1'b0;
    sel_stat = 1'b0;
    sel_count_low_field = 1'b0;
    sel_count_high_field = 1'b0;
    sel_compare_low_field = 1'b0;
    sel_compare_high_field = 1'b0;
    sel_evt = 1'b0;
    sel_mask = 1'b0;
    if (paddr == stt_evt_stat_addr)
      sel_evt = 1'b1;
    else if (paddr == stt_evt_mask_addr)
      sel_mask = 1'b1;
    else if (REDUCED)
    begin
      if (paddr == stt_red_ctrl_addr) // RULE14
        sel_ctrl = 1'b1;
      else if (paddr == stt_red_count_low_field_addr)
        sel_count_low_field = 1'b1;
      else if (paddr == stt_red_count_high_field_addr)
        sel_count_high_field = 1'b1;
      else if (paddr == stt_red_compare_low_field_addr)
        sel_compare_low_field = 1'b1;
      else if (paddr == stt_red_compare_high_field_addr)
        sel_compare_high_field = 1'b1;
    end
    else
    begin
      if (paddr == stt_full_ctrl_addr) // RULE13
        sel_ctrl = 1'b1;
      else if (paddr == stt_full_stat_addr)
        sel_stat = 1'b1;
      else if (paddr == stt_full_count_low_field_addr)
        sel_count_low_field = 1'b1;
      else if (paddr == stt_full_compare_low_field_addr)
        sel_compare_low_field = 1'b1;
    end
  end

  assign addr_hit = sel_ctrl | sel_stat | sel_count_low_field | sel_count_high_field | sel_compare_low_field | sel_compare_high_field |
                    sel_evt | sel_mask;
  // Reduced count and compare words refuse anything but a single-byte write.
  assign bad_write = REDUCED && pwrite && (sel_count_low_field | sel_count_high_field | sel_compare_low_field | sel_compare_high_field) &&
                     !one_lane(pstrb); // RULE11
  assign setup_done = psel & penable & ~pready;
  assign wr_fire = psel & penable & pready & pwrite;
  assign wr_ok = wr_fire & ~pslverr;

  // One wait state: answer is registered, so the access phase lasts two cycles.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= setup_done;
      if (setup_done)
      begin
        pslverr <= ~addr_hit | bad_write;
        prdata <= '0;
        if (!pwrite)
        begin
          if (sel_ctrl)
            prdata <= {{(32-stt_ctrl_bits){1'b0}}, ctrl_reg};
          else if (sel_stat)
            prdata <= {soft_trigger_reg, 30'h00000000, compare_flag_reg};
          else if (sel_count_low_field)
            prdata <= count_reg[31:0];
          else if (sel_count_high_field)
            prdata <= count_reg[63:32];
          else if (sel_compare_low_field)
            prdata <= compare_reg[31:0];
          else if (sel_compare_high_field)
            prdata <= compare_reg[63:32];
          else if (sel_evt)
            prdata <= {{(32-stt_evt_bits){1'b0}}, evt_stat_reg};
          else if (sel_mask)
            prdata <= {{(32-stt_evt_bits){1'b0}}, evt_mask_reg};
        end
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end

  // Control register; reduced keeps only the enable bit alive.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= stt_ctrl_reset[stt_ctrl_bits-1:0]; // RULE17
    else if (wr_ok && sel_ctrl && pstrb[0])
    begin
      if (REDUCED)
        ctrl_reg <= {{(stt_ctrl_bits-1){1'b0}}, pwdata[stt_ctrl_count_enable]}; // RULE12
      else
        ctrl_reg <= pwdata[stt_ctrl_bits-1:0];
    end
  end

  // Time base selection.
  stt_prescaler #(
    .DIV(stt_slow_div)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .tick_pulse(slow_pulse)
  );

  logic count_step;
  logic count_down;
  logic reload_on;
  logic [63:0] width_mask;
  logic [63:0] cmp_eff;
  logic [63:0] count_next;
  logic hit_event;

  assign width_mask = (cnt_w == 64) ? 64'hffffffffffffffff : 64'h00000000ffffffff; // RULE1
  assign cmp_eff = compare_reg & width_mask; // RULE10
  // The pclk domain is never gated, so counting goes on in light sleep.
  assign count_step = ctrl_reg[stt_ctrl_count_enable] & // RULE6 RULE15
                      ((!REDUCED && ctrl_reg[stt_ctrl_time_base]) | slow_pulse); // RULE2 RULE12
  assign count_down = !REDUCED && ctrl_reg[stt_ctrl_down]; // RULE3
  assign reload_on = !REDUCED && ctrl_reg[stt_ctrl_reload];

  always_comb
  begin
    count_next = count_reg;
    if (count_down)
    begin
      if (reload_on && count_reg == 64'h0000000000000000)
        count_next = cmp_eff; // RULE3
      else
        count_next = (count_reg - 64'h0000000000000001) & width_mask; // RULE4
    end
    else
    begin
      if (reload_on && count_reg == cmp_eff)
        count_next = 64'h0000000000000000; // RULE3
      else
        count_next = (count_reg + 64'h0000000000000001) & width_mask; // RULE4
    end
  end

  // Compare event: count lands on the compare value, or on zero going down.
  assign hit_event = count_step &&
                     (count_down ? (count_next == 64'h0000000000000000)
                                 : (count_next == cmp_eff)); // RULE8 RULE10

  // Counter; a software write takes priority over a step in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= stt_count_reset;
    else if (wr_ok && sel_count_low_field)
      count_reg[31:0] <= merge_bytes(count_reg[31:0], pwdata, pstrb);
    else if (wr_ok && sel_count_high_field)
      count_reg[63:32] <= merge_bytes(count_reg[63:32], pwdata, pstrb);
    else if (count_step)
      count_reg <= count_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_reg <= stt_count_reset;
    else if (wr_ok && sel_compare_low_field)
      compare_reg[31:0] <= merge_bytes(compare_reg[31:0], pwdata, pstrb);
    else if (wr_ok && sel_compare_high_field)
      compare_reg[63:32] <= merge_bytes(compare_reg[63:32], pwdata, pstrb);
  end

  // Compare flag: a write of 0 clears, a write of 1 is ignored, a hit wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_flag_reg <= stt_stat_reset[stt_stat_compare_flag]; // RULE17
    else if (!REDUCED && hit_event)
      compare_flag_reg <= 1'b1; // RULE7
    else if (wr_ok && sel_stat && pstrb[0] && !pwdata[stt_stat_compare_flag])
      compare_flag_reg <= 1'b0; // RULE7
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_trigger_reg <= stt_stat_reset[stt_stat_soft_trigger];
    else if (wr_ok && sel_stat && pstrb[3])
      soft_trigger_reg <= pwdata[stt_stat_soft_trigger]; // RULE9
  end

  // Event status: sticky, cleared by writing one; a new event wins.
  logic [stt_evt_bits-1:0] evt_in;

  assign evt_in = {soft_trigger_reg, hit_event};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_stat_reg <= '0;
    else
    begin
      for (int i = 0; i < stt_evt_bits; i++)
      begin
        if (evt_in[i])
          evt_stat_reg[i] <= 1'b1;
        else if (wr_ok && sel_evt && pstrb[0] && pwdata[i])
          evt_stat_reg[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      evt_mask_reg <= '0;
    else if (wr_ok && sel_mask && pstrb[0])
      evt_mask_reg <= pwdata[stt_evt_bits-1:0];
  end

  // Interrupt outputs, each from a flip-flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_irq <= 1'b0;
      soft_irq <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      if (REDUCED)
        tick_irq <= hit_event; // RULE8 RULE12
      else
        tick_irq <= compare_flag_reg & ctrl_reg[stt_ctrl_irq_enable]; // RULE5 RULE16
      soft_irq <= !REDUCED && soft_trigger_reg; // RULE9
      irq <= |(evt_stat_reg & evt_mask_reg);
    end
  end
endmodule // stt_tick_timer
`default_nettype wire

// ===== stt_tick_timer_props.sv
// Purpose: Port-level checks of the tick timer.
// Assumes: Full variant; APB access phase lasts two cycles.
// Notes: Bound to every timer instance.
`timescale 1ns/100ps
`default_nettype none
module stt_tick_timer_props
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [stt_pkg::stt_addr_w-1:0] paddr,
  input wire logic [stt_pkg::stt_data_w-1:0] pwdata,
  input wire logic [stt_pkg::stt_strb_w-1:0] pstrb,
  input wire logic [stt_pkg::stt_data_w-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Interrupts.
  input wire logic tick_irq,
  input wire logic soft_irq,
  input wire logic irq
);
  import stt_pkg::*;
  logic acc;
  logic wr;
  logic mapped;
  assign acc = psel && penable && !pready;
  assign wr = psel && penable && pready && pwrite;
  assign mapped = paddr inside {stt_full_ctrl_addr, stt_full_stat_addr, stt_full_count_low_field_addr,
    stt_full_compare_low_field_addr, stt_evt_stat_addr, stt_evt_mask_addr};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (acc |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_unmapped_err: assert property (acc && !mapped |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_soft_set: assert property (wr && paddr == stt_full_stat_addr && pstrb[3] && pwdata[31]
    |-> ##[1:2] soft_irq) else $error("soft irq not raised");
  a_soft_clear: assert property (wr && paddr == stt_full_stat_addr && pstrb[3] && !pwdata[31]
    |-> ##[1:2] !soft_irq) else $error("soft irq not dropped");
  a_tick_gate: assert property (wr && paddr == stt_full_ctrl_addr && pstrb[0] && !pwdata[1]
    |-> ##2 !tick_irq) else $error("tick irq not gated");
  a_mask_off: assert property (wr && paddr == stt_evt_mask_addr && pstrb[0] && pwdata[1:0] == 2'h0
    |-> ##2 !irq) else $error("irq not masked");
  a_reset_quiet: assert property ($rose(presetn) |-> !pready && !irq && !tick_irq && !soft_irq)
    else $error("outputs active after reset");
  c_soft: cover property (soft_irq);
  c_tick: cover property (tick_irq);
  c_refused: cover property (pready && pslverr);
  c_irq: cover property (irq);
endmodule // stt_tick_timer_props

bind stt_tick_timer stt_tick_timer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tick_irq(tick_irq),
  .soft_irq(soft_irq), .irq(irq));
`default_nettype wire

// ===== stt_tick_timer_tb.sv
// Purpose: Self-checking bench of the full tick timer.
// Assumes: Counter steps once per enabled clock with the fast base.
// Notes: Reads are noted in a queue and compared by a monitor.
`timescale 1ns/100ps
`default_nettype none
module stt_tick_timer_tb;
  import stt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tick_irq;
  logic soft_irq;
  logic irq;
  int err_count = 0;
  int num_checks = 0;
  logic [33:0] exp_q[$];
  logic [33:0] e_now;
  logic [31:0] last_rd;
  logic [31:0] c;
  logic [31:0] r;
  logic [31:0] m_ctrl [4] = '{32'h04, 32'h0c, 32'h14, 32'h1c};
  logic [31:0] m_start [4];
  logic [31:0] m_exp [4];

  always #5 pclk = ~pclk;

  stt_tick_timer #(.REDUCED(1'b0)) u_stt_tick_timer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick_irq(tick_irq), .soft_irq(soft_irq), .irq(irq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One transfer; k asks the monitor to compare read data with x.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic e, input logic k, input logic [31:0] x);
    exp_q.push_back({k, e, x});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The master waits for the answer; only the watchdog ends a hang.
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 1'b0, 32'h0);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 1'b0, 1'b1, x);
  endtask

  // Lets registered interrupt outputs follow a register write.
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask

  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      e_now = exp_q.pop_front();
      last_rd = prdata;
      check({31'h0, pslverr}, {31'h0, e_now[32]});
      if (e_now[33])
        check(prdata, e_now[31:0]);
    end
  end

  initial
  begin
    #100us;
    err_count++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(32'h2e88));
    c = ($urandom() % 32'hffffff00) + 32'h100;
    r = $urandom();
    m_start = '{c - 32'h2, c - 32'h2, 32'h1, 32'h2};
    m_exp = '{c + 32'h2, 32'h1, 32'hfffffffd, c - 32'h1};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(stt_full_ctrl_addr, 32'h0);
    rd(stt_full_stat_addr, 32'h0);
    apb(1'b0, 32'he000f030, 32'h0, 1'b1, 1'b1, 32'h0);
    apb(1'b1, 32'he000f00c, r, 1'b1, 1'b0, 32'h0);
    wr(stt_full_ctrl_addr, r & 32'hfffffffe);
    rd(stt_full_ctrl_addr, r & 32'h1e);
    wr(stt_full_ctrl_addr, 32'h0);
    wr(stt_full_compare_low_field_addr, c);
    rd(stt_full_compare_low_field_addr, c);
    // Each mode runs exactly four fast steps between start and stop.
    for (int i = 0; i < 4; i++)
    begin
      wr(stt_full_count_low_field_addr, m_start[i]);
      wr(stt_full_stat_addr, 32'h0);
      wr(stt_full_ctrl_addr, m_ctrl[i] | 32'h1);
      wr(stt_full_ctrl_addr, m_ctrl[i]);
      rd(stt_full_count_low_field_addr, m_exp[i]);
      rd(stt_full_stat_addr, 32'h1);
    end
    wr(stt_full_ctrl_addr, 32'h2);
    settle();
    check({31'h0, tick_irq}, 32'h1);
    wr(stt_full_ctrl_addr, 32'h0);
    settle();
    check({31'h0, tick_irq}, 32'h0);
    wr(stt_full_ctrl_addr, 32'h2);
    wr(stt_full_stat_addr, 32'h1);
    rd(stt_full_stat_addr, 32'h1);
    wr(stt_full_stat_addr, 32'h0);
    settle();
    check({31'h0, tick_irq}, 32'h0);
    rd(stt_full_stat_addr, 32'h0);
    wr(stt_evt_mask_addr, 32'h1);
    settle();
    check({31'h0, irq}, 32'h1);
    rd(stt_evt_stat_addr, 32'h1);
    wr(stt_evt_stat_addr, 32'h1);
    settle();
    check({31'h0, irq}, 32'h0);
    wr(stt_full_stat_addr, 32'h80000000);
    settle();
    check({31'h0, soft_irq}, 32'h1);
    rd(stt_full_stat_addr, 32'h80000000);
    wr(stt_evt_mask_addr, 32'h3);
    settle();
    check({31'h0, irq}, 32'h1);
    wr(stt_evt_mask_addr, 32'h0);
    settle();
    check({31'h0, irq}, 32'h0);
    wr(stt_full_stat_addr, 32'h0);
    settle();
    check({31'h0, soft_irq}, 32'h0);
    wr(stt_evt_stat_addr, 32'h3);
    rd(stt_evt_stat_addr, 32'h0);
    // Slow base over 84 clocks gives 10 or 11 steps, by prescaler phase.
    wr(stt_full_count_low_field_addr, 32'h0);
    wr(stt_full_ctrl_addr, 32'h1);
    repeat (80) @(posedge pclk);
    wr(stt_full_ctrl_addr, 32'h0);
    apb(1'b0, stt_full_count_low_field_addr, 32'h0, 1'b0, 1'b0, 32'h0);
    @(posedge pclk);
    check({31'h0, (last_rd == 32'ha || last_rd == 32'hb)}, 32'h1);
    end_of_test();
  end
endmodule // stt_tick_timer_tb
`default_nettype wire
